// ---- serial_cmd_map.svh ----
/*
  Constants of the serial command register block: frame fields, command
  codes, register addresses, reset values and bit positions.
  Assumes it is included by its bare name after the package is compiled.
*/
// Notes on behaviour
// - 16-bit frame: command, address, data, MSB first
// - every register holds exactly one byte
// - write now; read data returns next frame
// - commands accepted any time in normal state
// - execute only when chip select rises
// - codes 1/2 read/write configuration bank
// - codes 3/4 read/write status bank
// - codes 5/6 read/write control bank
// - code 0 checks; code 7 is reply
// - supply status bit 3 is serial error
// - supply status at address 13, flags cleared
// - three banks of four byte registers
// - configuration, control, status banks drive block
// - reset returns every register to default
// - check echoes low 12, inverts 14..12
// - bad count, command or address flags error
// - status writes clear only unless self-test
`ifndef SERIAL_CMD_MAP_SVH
`define SERIAL_CMD_MAP_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define FRAME_PULSES     8'h10
`define CHECK_INVERT     16'h7000
`define CHECK_KEEP       16'h0FFF

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_CHECK        4'h0
`define CMD_RD_CFG       4'h1
`define CMD_WR_CFG       4'h2
`define CMD_RD_STS       4'h3
`define CMD_WR_STS       4'h4
`define CMD_RD_CTL       4'h5
`define CMD_WR_CTL       4'h6

// ----------------------------------------------------------------------
// register addresses and bank bases
// ----------------------------------------------------------------------
`define CFG_ADDR_BASE    4'h0
`define CTL_ADDR_BASE    4'h0
`define STS_ADDR_BASE    4'hC
`define SUPPLY_STS_ADDR  4'hD
`define SUPPLY_STS_IDX   2'h1

// ----------------------------------------------------------------------
// reset values, one byte per register, register 0 in the low byte
// ----------------------------------------------------------------------
`define CFG_RESET        32'h10100010
`define CTL_RESET        32'h00000000
`define STS_RESET        32'h00000000
`define RESP_RESET       16'h0000

// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define SUPPLY_ANY_FAULT 3'h7
`define SUPPLY_SER_ERR   3'h3
`define SELF_TEST_IDX    2'h0
`define SELF_TEST_BIT    3'h7

`endif

// ---- serial_cmd_pkg.sv ----
/*
  Types of the serial command register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_cmd_pkg;

  typedef logic [3:0][7:0] bank_type;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } frame_type;

  // link side towards the core, stable while chip select is high
  typedef struct packed {
    frame_type  frame;
    logic [7:0] rise_cnt;
    logic [7:0] fall_cnt;
  } link_to_core_type;

  // core towards the link, changed only between frames
  typedef struct packed {
    logic [15:0] resp;
    logic [7:0]  fall_base;
  } core_to_link_type;

  typedef struct packed {
    logic [15:0] shift;
    logic [7:0]  rise_cnt;
  } link_rise_state_type;

  typedef struct packed {
    logic [2:0]  cs_sync;
    bank_type    cfg;
    bank_type    ctl;
    bank_type    sts;
    logic [15:0] resp;
    logic [7:0]  rise_base;
    logic [7:0]  fall_base;
    logic        frame_done;
    logic        frame_error;
  } core_state_type;

endpackage

// ---- serial_link_port.sv ----
/*
  Serial clock side of the command port: shifts the frame in on rising
  edges, counts edges, drives the reply out on falling edges.
  Assumes the serial clock stands low and still while chip select is high.
*/
`timescale 1ns/1ps
`default_nettype none

`include "serial_cmd_map.svh"

module serial_link_port (
  input  wire logic                             sclk,
  input  wire logic                             resetn,
  input  wire logic                             si,
  input  wire logic                             chip_select_n,
  input  wire serial_cmd_pkg::core_to_link_type to_link,
  output var  serial_cmd_pkg::link_to_core_type to_core,
  output logic                                  so_out,
  output logic                                  so_oe_n
);
  import serial_cmd_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  link_rise_state_type r_q;
  link_rise_state_type r_d;
  logic [7:0]          fall_q;
  logic [7:0]          idx;

  // counters free-run across frames; the core keeps the base of each
  // frame, so no reset has to cross into this clock
  always_comb begin
    r_d = r_q;
    if (!chip_select_n) begin
      r_d.shift    = {r_q.shift[14:0], si};
      r_d.rise_cnt = r_q.rise_cnt + 8'h01;
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      fall_q <= 8'h00;
    end else if (!chip_select_n) begin
      fall_q <= fall_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // reply bit: msb first, next bit after each falling edge
  // ----------------------------------------------------------------------
  always_comb begin
    idx    = fall_q - to_link.fall_base;
    so_out = 1'b0;
    if (idx < `FRAME_PULSES) begin
      so_out = to_link.resp[4'hF - idx[3:0]];
    end
  end

  assign so_oe_n          = chip_select_n;
  assign to_core.frame    = r_q.shift;
  assign to_core.rise_cnt = r_q.rise_cnt;
  assign to_core.fall_cnt = fall_q;

endmodule

`default_nettype wire

// ---- serial_cmd_regs.sv ----
/*
  Command decoder and register banks behind the 16-bit serial port.
  Each frame becomes a read or write of the configuration, control or
  status bank, or an integrity check, executed when chip select rises.
  Assumes the host keeps chip select high for at least four mclk periods
  between frames, so that the reply word settles before the next frame.
*/
`timescale 1ns/1ps
`default_nettype none

`include "serial_cmd_map.svh"

module serial_cmd_regs (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     sclk,
  input  wire logic                     si,
  input  wire logic                     chip_select_n,
  output logic                          so_out,
  output logic                          so_oe_n,
  input  wire serial_cmd_pkg::bank_type status_set,
  output var  serial_cmd_pkg::bank_type config_out,
  output var  serial_cmd_pkg::bank_type control_out,
  output var  serial_cmd_pkg::bank_type status_out,
  output logic                          power_on_self_test,
  output logic                          frame_done,
  output logic                          frame_error
);
  import serial_cmd_pkg::*;

  // ----------------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------------
  link_to_core_type link;
  core_to_link_type to_link;
  core_state_type   s_q;
  core_state_type   s_d;

  serial_link_port link_port (
    .sclk          (sclk),
    .resetn        (resetn),
    .si            (si),
    .chip_select_n (chip_select_n),
    .to_link       (to_link),
    .to_core       (link),
    .so_out        (so_out),
    .so_oe_n       (so_oe_n)
  );

  assign to_link.resp      = s_q.resp;
  assign to_link.fall_base = s_q.fall_base;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // each bank answers four consecutive addresses from its base
  function automatic logic in_bank(input logic [3:0] addr,
                                   input logic [3:0] base);
    logic [3:0] off;
    off     = addr - base;
    in_bank = (addr >= base) && (off < 4'h4);
  endfunction

  function automatic logic [1:0] bank_idx(input logic [3:0] addr,
                                          input logic [3:0] base);
    logic [3:0] off;
    off      = addr - base;
    bank_idx = off[1:0];
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  frame_type  frame;
  logic [7:0] pulses;
  logic       cs_rise;
  logic       self_test;
  logic       bad;
  logic [1:0] idx;
  logic       fault_seen;

  // ----------------------------------------------------------------------
  // hardware status sets, one lane per status register
  // ----------------------------------------------------------------------
  // while self-test is on, faults on status_set do not reach the status bank, so a
  // test pattern written by software is not disturbed
  bank_type   hw_set;
  logic [3:0] hw_hit;

  assign self_test = s_q.ctl[`SELF_TEST_IDX][`SELF_TEST_BIT];

  for (genvar g = 0; g < 4; g++) begin : g_hw_lane
    assign hw_set[g] = self_test ? 8'h00 : status_set[g];
    assign hw_hit[g] = (hw_set[g] != 8'h00);
  end

  always_comb begin
    s_d             = s_q;
    s_d.frame_done  = 1'b0;
    s_d.frame_error = 1'b0;
    frame           = link.frame;
    pulses          = link.rise_cnt - s_q.rise_base;
    idx             = 2'h0;
    bad             = 1'b0;
    fault_seen      = 1'b0;

    // chip select crosses by two flops; bit 2 only delays bit 1
    s_d.cs_sync = {s_q.cs_sync[1:0], chip_select_n};
    cs_rise     = s_q.cs_sync[1] && !s_q.cs_sync[2];

    // ------------------------------------------------------------------
    // command execution at the end of a frame
    // ------------------------------------------------------------------
    // link counters are still here: the serial clock idles with select high
    if (cs_rise) begin
      s_d.rise_base  = link.rise_cnt;
      s_d.fall_base  = link.fall_cnt;
      s_d.frame_done = 1'b1;

      if (pulses != `FRAME_PULSES) begin
        bad = 1'b1;
      end else begin
        case (frame.cmd)
          `CMD_CHECK: begin
            s_d.resp = (link.frame & `CHECK_KEEP) | `CHECK_INVERT;
          end
          `CMD_RD_CFG: begin
            if (in_bank(frame.addr, `CFG_ADDR_BASE)) begin
              idx      = bank_idx(frame.addr, `CFG_ADDR_BASE);
              s_d.resp = {frame.cmd, frame.addr, s_q.cfg[idx]};
            end else begin
              bad = 1'b1;
            end
          end
          `CMD_WR_CFG: begin
            if (in_bank(frame.addr, `CFG_ADDR_BASE)) begin
              idx          = bank_idx(frame.addr, `CFG_ADDR_BASE);
              s_d.cfg[idx] = frame.data;
              s_d.resp     = {frame.cmd, frame.addr, frame.data};
            end else begin
              bad = 1'b1;
            end
          end
          `CMD_RD_STS: begin
            if (in_bank(frame.addr, `STS_ADDR_BASE)) begin
              idx      = bank_idx(frame.addr, `STS_ADDR_BASE);
              s_d.resp = {frame.cmd, frame.addr, s_q.sts[idx]};
            end else begin
              bad = 1'b1;
            end
          end
          `CMD_WR_STS: begin
            if (in_bank(frame.addr, `STS_ADDR_BASE)) begin
              idx = bank_idx(frame.addr, `STS_ADDR_BASE);
              // clear-only unless self-test lets software set bits too
              if (self_test) begin
                s_d.sts[idx] = frame.data;
              end else begin
                s_d.sts[idx] = s_q.sts[idx] & frame.data;
              end
              s_d.resp = {frame.cmd, frame.addr, s_d.sts[idx]};
            end else begin
              bad = 1'b1;
            end
          end
          `CMD_RD_CTL: begin
            if (in_bank(frame.addr, `CTL_ADDR_BASE)) begin
              idx      = bank_idx(frame.addr, `CTL_ADDR_BASE);
              s_d.resp = {frame.cmd, frame.addr, s_q.ctl[idx]};
            end else begin
              bad = 1'b1;
            end
          end
          `CMD_WR_CTL: begin
            if (in_bank(frame.addr, `CTL_ADDR_BASE)) begin
              idx          = bank_idx(frame.addr, `CTL_ADDR_BASE);
              s_d.ctl[idx] = frame.data;
              s_d.resp     = {frame.cmd, frame.addr, frame.data};
            end else begin
              bad = 1'b1;
            end
          end
          // the check reply code and codes 8 to 15 are not commands
          default: begin
            bad = 1'b1;
          end
        endcase
      end

      // a refused frame changes nothing but the supply status error flags and leaves the old reply in place
      if (bad) begin
        s_d.cfg         = s_q.cfg;
        s_d.ctl         = s_q.ctl;
        s_d.sts         = s_q.sts;
        s_d.resp        = s_q.resp;
        s_d.frame_error = 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // hardware status sets, applied after the host write so a set wins
    // ------------------------------------------------------------------
    s_d.sts    = s_d.sts | hw_set;
    fault_seen = (hw_hit != 4'h0);

    // serial error is always recorded, even during self-test
    if (s_d.frame_error) begin
      s_d.sts[`SUPPLY_STS_IDX][`SUPPLY_SER_ERR] = 1'b1;
      fault_seen = 1'b1;
    end

    if (fault_seen) begin
      s_d.sts[`SUPPLY_STS_IDX][`SUPPLY_ANY_FAULT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q.cs_sync     <= 3'h7;
      s_q.cfg         <= `CFG_RESET;
      s_q.ctl         <= `CTL_RESET;
      s_q.sts         <= `STS_RESET;
      s_q.resp        <= `RESP_RESET;
      s_q.rise_base   <= 8'h00;
      s_q.fall_base   <= 8'h00;
      s_q.frame_done  <= 1'b0;
      s_q.frame_error <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign config_out         = s_q.cfg;
  assign control_out        = s_q.ctl;
  assign status_out         = s_q.sts;
  assign power_on_self_test = s_q.ctl[`SELF_TEST_IDX][`SELF_TEST_BIT];
  assign frame_done         = s_q.frame_done;
  assign frame_error        = s_q.frame_error;

endmodule

`default_nettype wire

// ---- serial_cmd_monitor.sv ----
/*
  Port checker for the serial command register block.
  Assumes it is bound to serial_cmd_regs and clocked by mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_cmd_monitor (
  input wire logic                     mclk,
  input wire logic                     resetn,
  input wire logic                     chip_select_n,
  input wire logic                     so_oe_n,
  input wire serial_cmd_pkg::bank_type config_out,
  input wire serial_cmd_pkg::bank_type control_out,
  input wire serial_cmd_pkg::bank_type status_out,
  input wire serial_cmd_pkg::bank_type status_set,
  input wire logic                     power_on_self_test,
  input wire logic                     frame_done,
  input wire logic                     frame_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  oe_follows_cs_a: assert property (
    so_oe_n == chip_select_n) else $error("so enable not chip select");
  done_after_rise_a: assert property (
    frame_done |-> chip_select_n && $past(chip_select_n, 2))
    else $error("frame done without chip select rise");
  done_pulse_a: assert property (
    frame_done |=> !frame_done) else $error("frame done too long");

  // ----------------------------------------------------------------
  // register updates
  // ----------------------------------------------------------------
  cfg_hold_a: assert property (
    !frame_done |-> $stable(config_out)) else $error("config moved");
  ctl_hold_a: assert property (
    !frame_done |-> $stable(control_out)) else $error("control moved");
  err_hold_a: assert property (
    frame_error |-> $stable(config_out) && $stable(control_out))
    else $error("refused frame changed a register");
  err_done_a: assert property (
    frame_error |-> frame_done) else $error("error without done");
  err_flag_a: assert property (
    frame_error |-> status_out[1][3] && status_out[1][7])
    else $error("serial error flag not set");
  power_on_self_test_bit_a: assert property (
    power_on_self_test == control_out[0][7])
    else $error("self test output differs from control bit");
  sts_hold_a: assert property (
    !frame_done && ($past(status_set) == 32'h0) |-> $stable(status_out))
    else $error("status moved without a cause");
  power_on_self_test_gate_a: assert property (
    $past(power_on_self_test) && !frame_done |-> $stable(status_out))
    else $error("status moved during self test");
endmodule

bind serial_cmd_regs serial_cmd_monitor mon_u (
  .mclk(mclk), .resetn(resetn), .chip_select_n(chip_select_n),
  .so_oe_n(so_oe_n), .config_out(config_out), .control_out(control_out),
  .status_out(status_out), .status_set(status_set),
  .power_on_self_test(power_on_self_test),
  .frame_done(frame_done), .frame_error(frame_error)
);

`default_nettype wire

// ---- serial_host_model.sv ----
/*
  Host model: serial master with a 64 ns clock that runs only in frames.
  Assumes so_line already resolves the released output.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  output var logic sclk,
  output var logic si,
  output var logic chip_select_n,
  input  wire logic so_line
);
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    chip_select_n = 1'b1;
  end

  // n pulses; a count other than 16 is only sent to provoke a refusal
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    si = w[15];
    chip_select_n = 1'b0;
    #40;
    for (int k = 0; k < n; k++) begin
      sclk = 1'b1;
      r = {r[14:0], so_line};
      #32;
      sclk = 1'b0;
      si = (k < 15) ? w[14-k] : ~si;
      #32;
    end
    chip_select_n = 1'b1;
    // long gap: execution and spacing before the next frame
    #500;
  endtask
endmodule

`default_nettype wire

// ---- serial_cmd_regs_tb_top.sv ----
/*
  Self-checking bench of the serial command register block.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_cmd_regs_tb_top;
  import serial_cmd_pkg::*;
  logic        mclk, resetn, sclk, si, chip_select_n;
  logic        so_out, so_oe_n, so_last, power_on_self_test;
  logic        frame_done, frame_error;
  bank_type    status_set, config_out, control_out, status_out;
  logic [15:0] rep;
  int          bad_count, check_count, done_cnt, err_cnt;
  // a released line shows no stale value
  wire         so_line = so_oe_n ? ~so_last : so_out;

  always @(so_out or so_oe_n) if (!so_oe_n) so_last = so_out;
  always @(posedge mclk) begin
    if (frame_done === 1'b1) done_cnt++;
    if (frame_error === 1'b1) err_cnt++;
  end

  serial_cmd_regs dut_u (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .si(si),
    .chip_select_n(chip_select_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .status_set(status_set), .config_out(config_out),
    .control_out(control_out), .status_out(status_out),
    .power_on_self_test(power_on_self_test),
    .frame_done(frame_done), .frame_error(frame_error)
  );
  serial_host_model host_u (
    .sclk(sclk), .si(si), .chip_select_n(chip_select_n),
    .so_line(so_line)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic send(input logic [15:0] w, input int n, input int err);
    int d0, e0;
    d0 = done_cnt;
    e0 = err_cnt;
    host_u.xfer(w, n, rep);
    chk("frame done", 32'(d0 + 1), 32'(done_cnt));
    chk("frame error", 32'(e0 + err), 32'(err_cnt));
  endtask

  task automatic t_defaults;
    chk("config", 32'h10100010, config_out);
    chk("control", 32'h00000000, control_out);
    chk("status", 32'h00000000, status_out);
    chk("self test", 32'h0, {31'h0, power_on_self_test});
    send(16'h1200, 16, 0);
    chk("reset reply", 32'h0, {16'h0, rep});
    send(16'h0000, 16, 0);
    chk("config read", 32'h1210, {16'h0, rep});
    $display("test defaults done");
  endtask

  task automatic t_bank(input logic [3:0] wr, input logic [3:0] rd,
                        input int ctl);
    for (int i = 0; i < 4; i++) begin
      send({wr, 4'(i), 8'h30 + 8'(i)}, 16, 0);
      send({rd, 4'(i), 8'h00}, 16, 0);
      send(16'h0000, 16, 0);
      chk("read reply", {16'h0, rd, 4'(i), 8'h30 + 8'(i)},
          {16'h0, rep});
      chk("bank", 32'h30 + 32'(i),
          {24'h0, ctl ? control_out[i] : config_out[i]});
    end
    $display("test bank %h done", wr);
  endtask

  task automatic t_check;
    send(16'h0ABC, 16, 0);
    send(16'h0000, 16, 0);
    chk("check reply", 32'h7ABC, {16'h0, rep});
    $display("test check done");
  endtask

  task automatic t_refuse;
    bank_type c0;
    c0 = config_out;
    for (int c = 7; c < 16; c++) send({4'(c), 8'h00, 4'h1}, 16, 1);
    send(16'h2577, 16, 1);
    send(16'h2055, 15, 1);
    send(16'h2055, 17, 1);
    chk("config kept", c0, config_out);
    chk("supply status", 32'h88, {24'h0, status_out[1]});
    $display("test refuse done");
  endtask

  task automatic t_status;
    @(negedge mclk) status_set[1] = 8'h07;
    @(negedge mclk) status_set = '0;
    @(negedge mclk);
    chk("fault set", 32'h8F, {24'h0, status_out[1]});
    send(16'h4DF6, 16, 0);
    chk("clear only", 32'h86, {24'h0, status_out[1]});
    send(16'h6080, 16, 0);
    chk("self test on", 32'h1, {31'h0, power_on_self_test});
    @(negedge mclk) status_set[1] = 8'h01;
    @(negedge mclk) status_set = '0;
    @(negedge mclk);
    chk("fault gated", 32'h86, {24'h0, status_out[1]});
    send(16'h4D55, 16, 0);
    chk("self test write", 32'h55, {24'h0, status_out[1]});
    send(16'h3D00, 16, 0);
    send(16'h6000, 16, 0);
    chk("status read", 32'h3D55, {16'h0, rep});
    chk("self test off", 32'h0, {31'h0, power_on_self_test});
    $display("test status done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    status_set = '0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    t_defaults();
    t_bank(4'h2, 4'h1, 0);
    t_bank(4'h6, 4'h5, 1);
    t_check();
    t_refuse();
    t_status();
    @(negedge mclk) resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    t_defaults();
    finish_test();
  end
endmodule

`default_nettype wire
